// [hw/tsb_pkg.sv]
// tsb_pkg: address map, field layout and constants of the timer block
// Contract
// - each of the six channels may be marked for synchronous operation
// - a counter write to one sync channel loads every sync channel together
// - clear select offers sync clear, following other sync channels' clears
// - a channel counts only while its count start bit is one
// - only channels 0 and 3 buffer: C buffers A, D buffers B
// - buffered compare: each match copies buffer register into general register
// - buffered capture: counter to general register, old value to buffer
// - cascade select on channel 1 or 4 counts channel 2 or 5 carries
// - the lower counter underflows only in phase counting mode
// - phase counting on channel 1 or 4 overrides the cascade select
// - upper counter increments on lower overflow, decrements on lower underflow
// - simultaneous captures store upper and lower halves into the A registers
// - pwm compare matches drive low, high or toggle; clear match sets period
// - each channel enters pwm mode on its own, also with synchronous operation
// - pwm 1 pairs A/B and C/D; A and C pins follow both matches
// - pwm 1 pins start at the initial level of register A or C
// - pwm 1 with equal paired registers leaves the pin unchanged
// - pwm 1 gives at most eight output phases over all channels
// - pwm 2 duty pins return to initial level when the period clears
// - pwm 2 duty equal to period leaves the pin unchanged on match
// - pwm 2 with synchronous operation gives at most fifteen phases
// - pwm 2 pin of the period register carries no waveform
// - start begins counting; a clear-source match resets the counter to zero
// - phase counting on channels 1, 2, 4, 5 counts up and down
package tsb_pkg;
	localparam int          NCH         = 6;
	localparam int          PSC_STEP    = 2;
	localparam logic [7:0]  ADDR_START  = 8'h00;
	localparam logic [7:0]  ADDR_SYNC   = 8'h04;
	// channel n occupies byte addresses (n + 1) * 32 onward
	localparam logic [2:0]  CH_BASE     = 3'h1;
	localparam logic [2:0]  OFS_CTRL    = 3'h0;
	localparam logic [2:0]  OFS_IOC     = 3'h1;
	localparam logic [2:0]  OFS_CNT     = 3'h2;
	localparam logic [2:0]  OFS_GRA     = 3'h3;
	localparam logic [2:0]  OFS_GRD     = 3'h6;
	localparam int          PSC_LSB     = 0;
	localparam int          CCLR_LSB    = 3;
	localparam int          MODE_LSB    = 6;
	localparam int          BUFA_BIT    = 8;
	localparam int          BUFB_BIT    = 9;
	localparam logic [2:0]  PSC_CASCADE = 3'h7;
	localparam logic [2:0]  CCLR_A      = 3'h1;
	localparam logic [2:0]  CCLR_B      = 3'h2;
	localparam logic [2:0]  CCLR_SYNC   = 3'h3;
	localparam logic [2:0]  CCLR_C      = 3'h5;
	localparam logic [2:0]  CCLR_D      = 3'h6;
	localparam logic [2:0]  PER_NONE    = 3'h4;
	localparam logic [1:0]  MODE_PWM1   = 2'h1;
	localparam logic [1:0]  MODE_PWM2   = 2'h2;
	localparam logic [1:0]  MODE_PHASE  = 2'h3;
	localparam int          IO_ACT_LSB  = 0;
	localparam int          IO_INIT_BIT = 2;
	localparam int          IO_CAP_BIT  = 3;
	localparam logic [1:0]  ACT_NONE    = 2'h0;
	localparam logic [1:0]  ACT_LOW     = 2'h1;
	localparam logic [1:0]  ACT_HIGH    = 2'h2;
	localparam logic [1:0]  CAP_RISE    = 2'h0;
	localparam logic [1:0]  CAP_FALL    = 2'h1;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] GR_RESET    = 16'hFFFF;
endpackage : tsb_pkg

// [hw/tsb_timer.sv]
// tsb_timer: six-channel timer with sync, buffer, cascade and pwm modes
module tsb_timer #(
	parameter int PSC_W = 12
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	input  wire logic [3:0]                extClk,
	input  wire logic [tsb_pkg::NCH-1:0]   pinAIn,
	input  wire logic [tsb_pkg::NCH-1:0]   pinBIn,
	input  wire logic [tsb_pkg::NCH-1:0]   pinCIn,
	input  wire logic [tsb_pkg::NCH-1:0]   pinDIn,
	output logic [tsb_pkg::NCH-1:0]        pinAOut,
	output logic [tsb_pkg::NCH-1:0]        pinBOut,
	output logic [tsb_pkg::NCH-1:0]        pinCOut,
	output logic [tsb_pkg::NCH-1:0]        pinDOut,
	output logic [tsb_pkg::NCH-1:0]        pinAOe_n,
	output logic [tsb_pkg::NCH-1:0]        pinBOe_n,
	output logic [tsb_pkg::NCH-1:0]        pinCOe_n,
	output logic [tsb_pkg::NCH-1:0]        pinDOe_n
);
	import tsb_pkg::*;

	localparam int NP = 4 * NCH + 4;

	logic [15:0]      ctrl_q [NCH];
	logic [15:0]      ioc_q  [NCH];
	logic [15:0]      cnt_q  [NCH];
	logic [15:0]      gr_q   [NCH][4];
	logic [NCH-1:0]   start_q;
	logic [NCH-1:0]   sync_q;
	logic [PSC_W-1:0] presc_q;
	logic [NCH-1:0]   ovf;
	logic [NCH-1:0]   unf;
	logic [NCH-1:0]   clrOwn;
	logic [NCH-1:0]   cntLoad;
	logic [4*NCH-1:0] pinLvl;
	logic [4*NCH-1:0] pinOe_n;

	function automatic logic lvl(input logic [1:0] a, input logic cur);
		return (a == ACT_NONE) ? cur : (a == ACT_LOW) ? 1'b0 :
			(a == ACT_HIGH) ? 1'b1 : !cur;
	endfunction : lvl

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [NP-1:0] in1_q;
	logic [NP-1:0] in2_q;
	logic [NP-1:0] in3_q;
	logic [NP-1:0] flt_q;
	wire  [NP-1:0] rawIn = {extClk, pinDIn, pinCIn, pinBIn, pinAIn};
	wire  [NP-1:0] agree = ~(in2_q ^ in3_q);
	wire  [NP-1:0] fltD  = (agree & in3_q) | (~agree & flt_q);
	wire  [NP-1:0] rise  = fltD & ~flt_q;
	wire  [NP-1:0] fall  = ~fltD & flt_q;

	always_ff @(posedge ref_clk) begin
		in1_q <= rawIn;
		in2_q <= in1_q;
		in3_q <= in2_q;
		flt_q <= rst_n ? fltD : '0;
	end

	// ****************************************************************
	// ahb-lite slave, zero wait states
	// ****************************************************************
	logic        wrPend_q;
	logic [7:0]  wrAddr_q;
	logic [31:0] rdata_q;
	wire         addrPh  = hsel && htrans[1] && hready;
	wire  [2:0]  wrOfs   = wrAddr_q[4:2];
	wire  [15:0] wrData  = hwdata[15:0];
	wire  [2:0]  rdSlot  = haddr[7:5] - CH_BASE;
	wire  [2:0]  rdOfs   = haddr[4:2];
	wire         rdInCh  = haddr[7:5] >= CH_BASE && rdSlot < 3'(NCH);
	wire         rdIsGr  = rdOfs >= OFS_GRA && rdOfs <= OFS_GRD;
	wire  [1:0]  rdGr    = 2'(rdOfs - OFS_GRA);
	wire  [15:0] rdChVal = (rdOfs == OFS_CTRL) ? ctrl_q[rdSlot] :
		(rdOfs == OFS_IOC) ? ioc_q[rdSlot] :
		(rdOfs == OFS_CNT) ? cnt_q[rdSlot] :
		rdIsGr ? gr_q[rdSlot][rdGr] : CNT_ZERO;
	wire  [15:0] rdVal   = (haddr[7:0] == ADDR_START) ? 16'(start_q) :
		(haddr[7:0] == ADDR_SYNC) ? 16'(sync_q) :
		rdInCh ? rdChVal : CNT_ZERO;
	wire         startWr = wrPend_q && wrAddr_q == ADDR_START;
	wire         syncWr  = wrPend_q && wrAddr_q == ADDR_SYNC;
	// a counter write on any synchronous channel presets all of them
	wire         syncPre = |(cntLoad & sync_q);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			rdata_q  <= 32'h00000000;
			start_q  <= '0;
			sync_q   <= '0;
			presc_q  <= '0;
		end else begin
			wrPend_q <= addrPh && hwrite;
			wrAddr_q <= haddr[7:0];
			if (addrPh && !hwrite) begin
				rdata_q <= 32'(rdVal);
			end
			if (startWr) begin
				start_q <= wrData[NCH-1:0];
			end
			if (syncWr) begin
				sync_q <= wrData[NCH-1:0];
			end
			presc_q <= presc_q + 1'b1;
		end
	end

	// ****************************************************************
	// channels
	// ****************************************************************
	for (genvar j = 0; j < NCH; j++) begin : g_ch
		// only channels 0 and 3 own C and D registers and buffers
		localparam bit HasCd = (j == 0) || (j == 3);
		localparam bit CanCas = (j == 1) || (j == 4);
		localparam int CB = 4 * NCH + (((j == 2) || (j == 4)) ? 2 : 0);
		localparam logic [NCH-1:0] OTH = ~(NCH'(1) << j);
		wire [2:0]  psc     = ctrl_q[j][PSC_LSB +: 3];
		wire [2:0]  cclr    = ctrl_q[j][CCLR_LSB +: 3];
		wire [1:0]  mode    = ctrl_q[j][MODE_LSB +: 2];
		wire [1:0]  bufOn   = {HasCd && ctrl_q[j][BUFB_BIT],
			HasCd && ctrl_q[j][BUFA_BIT]};
		wire        isPhase = !HasCd && mode == MODE_PHASE;
		wire        isPwm1  = mode == MODE_PWM1;
		wire        isPwm2  = mode == MODE_PWM2;
		wire        run     = start_q[j];
		wire        aL      = flt_q[CB];
		wire        bL      = flt_q[CB+1];
		wire        aR      = rise[CB];
		wire        aF      = fall[CB];
		wire        bR      = rise[CB+1];
		wire        bF      = fall[CB+1];
		wire        phUp    = (aR && !bL) || (aF && bL) || (bR && aL)
			|| (bF && !aL);
		wire        phDn    = (aR && bL) || (aF && !bL) || (bR && !aL)
			|| (bF && aL);
		wire        cascade = CanCas && psc == PSC_CASCADE && !isPhase;
		wire [PSC_W-1:0] pmask = ~({PSC_W{1'b1}} << (PSC_STEP * psc));
		wire        tick    = (presc_q & pmask) == '0 && psc != PSC_CASCADE;
		wire        up      = run && (isPhase ? phUp :
			cascade ? ovf[(j+1)%NCH] : tick);
		wire        dn      = run && (isPhase ? phDn :
			cascade && unf[(j+1)%NCH]);
		wire [2:0]  perIdx  = (cclr == CCLR_A) ? 3'h0 : (cclr == CCLR_B) ? 3'h1 :
			(cclr == CCLR_C && HasCd) ? 3'h2 :
			(cclr == CCLR_D && HasCd) ? 3'h3 : PER_NONE;
		logic [3:0] match;
		logic [3:0] cap;
		wire  [3:0] ev      = match | cap;
		wire        clrSync = run && sync_q[j] && cclr == CCLR_SYNC
			&& |(clrOwn & sync_q & OTH);
		wire        clr     = clrOwn[j] || clrSync;
		wire        selWr   = wrPend_q && wrAddr_q[7:5] == 3'(j) + CH_BASE;

		assign ovf[j]     = up && cnt_q[j] == CNT_MAX;
		assign unf[j]     = dn && isPhase && cnt_q[j] == CNT_ZERO;
		assign clrOwn[j]  = run && perIdx != PER_NONE && ev[perIdx[1:0]];
		assign cntLoad[j] = selWr && wrOfs == OFS_CNT;

		for (genvar r = 0; r < 4; r++) begin : g_r
			localparam int P  = r * NCH + j;
			localparam int PA = r & 2;
			wire [3:0] io     = ioc_q[j][4*r +: 4];
			wire [1:0] act    = io[IO_ACT_LSB +: 2];
			wire [1:0] actB   = ioc_q[j][4*(PA+1)+IO_ACT_LSB +: 2];
			wire       init   = io[IO_INIT_BIT];
			wire       en     = (r < 2) || (HasCd && !bufOn[r%2]);
			wire       edgeOk = (act == CAP_RISE) ? rise[P] :
				(act == CAP_FALL) ? fall[P] : (rise[P] || fall[P]);
			wire       pairEq = gr_q[j][PA] == gr_q[j][PA+1];
			wire       perEq  = perIdx != PER_NONE
				&& gr_q[j][r] == gr_q[j][perIdx[1:0]];
			wire       isPer  = perIdx == 3'(r);
			// pwm 1 waveform appears only on the A and C pins
			wire       drive  = en && (isPwm1 ? (r % 2 == 0) :
				isPwm2 ? !isPer : (!io[IO_CAP_BIT] && act != ACT_NONE));
			logic      pin_q;
			wire       pwm1D  = pairEq ? pin_q :
				match[PA+1] ? lvl(actB, pin_q) :
				match[PA] ? lvl(act, pin_q) : pin_q;
			wire       pwm2D  = (isPer || clr) ? init :
				(match[r] && !perEq) ? lvl(act, pin_q) : pin_q;
			wire       pinD   = !run ? init :
				isPwm1 ? pwm1D : isPwm2 ? pwm2D :
				match[r] ? lvl(act, pin_q) : pin_q;

			assign cap[r]   = en && io[IO_CAP_BIT] && edgeOk;
			assign match[r] = en && !io[IO_CAP_BIT] && (up || dn)
				&& cnt_q[j] == gr_q[j][r];
			// 8 pwm 1 phases and 16 pins less one period register
			assign pinLvl[P]  = pin_q;
			assign pinOe_n[P] = !drive;

			always_ff @(posedge ref_clk) begin
				pin_q <= rst_n ? pinD : 1'b0;
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				ctrl_q[j] <= CNT_ZERO;
				ioc_q[j]  <= CNT_ZERO;
				cnt_q[j]  <= CNT_ZERO;
			end else begin
				if (selWr && wrOfs == OFS_CTRL) begin
					ctrl_q[j] <= wrData;
				end
				if (selWr && wrOfs == OFS_IOC) begin
					ioc_q[j] <= wrData;
				end
				if (cntLoad[j] || (sync_q[j] && syncPre)) begin
					cnt_q[j] <= wrData;
				end else if (clr) begin
					cnt_q[j] <= CNT_ZERO;
				end else if (up) begin
					cnt_q[j] <= cnt_q[j] + 1'b1;
				end else if (dn) begin
					cnt_q[j] <= cnt_q[j] - 1'b1;
				end
			end
		end

		always_ff @(posedge ref_clk) begin
			for (int r = 0; r < 4; r++) begin
				if (!rst_n) begin
					gr_q[j][r] <= GR_RESET;
				end else if (selWr && wrOfs == 3'(r + OFS_GRA)) begin
					gr_q[j][r] <= wrData;
				end else if (cap[r]) begin
					gr_q[j][r] <= cnt_q[j];
				end else if (r < 2 && match[r] && bufOn[r%2]) begin
					gr_q[j][r] <= gr_q[j][(r+2)%4];
				end else if (r >= 2 && cap[r%2] && bufOn[r%2]) begin
					gr_q[j][r] <= gr_q[j][r%2];
				end
			end
		end
	end

	assign pinAOut  = pinLvl[0 +: NCH];
	assign pinBOut  = pinLvl[NCH +: NCH];
	assign pinCOut  = pinLvl[2*NCH +: NCH];
	assign pinDOut  = pinLvl[3*NCH +: NCH];
	assign pinAOe_n = pinOe_n[0 +: NCH];
	assign pinBOe_n = pinOe_n[NCH +: NCH];
	assign pinCOe_n = pinOe_n[2*NCH +: NCH];
	assign pinDOe_n = pinOe_n[3*NCH +: NCH];

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_stopped_hold:
	assert property (!start_q[0] && !cntLoad[0] && !syncPre
		|=> cnt_q[0] == $past(cnt_q[0]))
	else $error("stopped counter moved");

	a_sync_preset:
	assert property (syncPre && sync_q[1] |=> cnt_q[1] == $past(hwdata[15:0]))
	else $error("sync preset missed");

	a_match_clear:
	assert property (g_ch[0].clr && !syncPre && !cntLoad[0]
		|=> cnt_q[0] == CNT_ZERO)
	else $error("clear source did not zero counter");

	a_sync_clear:
	assert property (g_ch[1].cclr == CCLR_SYNC && sync_q[1] && sync_q[0]
		&& start_q[1] && clrOwn[0] && !syncPre && !cntLoad[1]
		|=> cnt_q[1] == CNT_ZERO)
	else $error("sync clear missed");

	a_buffer_compare:
	assert property (g_ch[0].match[0] && g_ch[0].bufOn[0] && !wrPend_q
		|=> gr_q[0][0] == $past(gr_q[0][2]))
	else $error("buffer not copied on match");

	a_buffer_capture:
	assert property (g_ch[3].cap[0] && g_ch[3].bufOn[0] && !wrPend_q
		|=> gr_q[3][2] == $past(gr_q[3][0]) && gr_q[3][0] == $past(cnt_q[3]))
	else $error("capture buffer shift wrong");

	a_cascade_carry:
	assert property (g_ch[1].cascade && start_q[1] && ovf[2] && !g_ch[1].clr
		&& !syncPre && !cntLoad[1]
		|=> cnt_q[1] == 16'($past(cnt_q[1]) + 16'h0001))
	else $error("cascade carry lost");

	a_no_underflow:
	assert property (!g_ch[2].isPhase |-> !unf[2])
	else $error("underflow outside phase mode");

	a_pwm1_equal:
	assert property (g_ch[4].isPwm1 && start_q[4] && g_ch[4].g_r[0].pairEq
		|=> pinAOut[4] == $past(pinAOut[4]))
	else $error("pwm1 pin moved with equal pair");

	a_pwm2_restart:
	assert property (g_ch[5].isPwm2 && start_q[5] && g_ch[5].clr
		&& !g_ch[5].g_r[0].isPer
		|=> pinAOut[5] == $past(g_ch[5].g_r[0].init))
	else $error("pwm2 pin not back to initial");

	a_pin_initial:
	assert property (!start_q[4]
		|=> pinAOut[4] == $past(g_ch[4].g_r[0].init))
	else $error("idle pin not at initial level");

	a_pwm1_b_idle:
	assert property (g_ch[4].isPwm1 |-> pinBOe_n[4])
	else $error("pwm1 drove a B pin");

	a_period_pin:
	assert property (g_ch[5].isPwm2 && g_ch[5].g_r[1].isPer |-> pinBOe_n[5])
	else $error("pwm2 period pin driven");

	a_phase_up:
	assert property (g_ch[2].isPhase && start_q[2] && g_ch[2].phUp
		&& !g_ch[2].clr && !syncPre && !cntLoad[2]
		|=> cnt_q[2] == 16'($past(cnt_q[2]) + 16'h0001))
	else $error("phase up count lost");

	c_cascade: cover property (g_ch[1].cascade && ovf[2] && start_q[1]);
	c_buffer: cover property (g_ch[0].match[0] && g_ch[0].bufOn[0]);
	c_capture: cover property (g_ch[3].cap[0] && g_ch[3].bufOn[0]);
	c_pwm1: cover property (g_ch[4].isPwm1 && pinAOut[4] && !$past(pinAOut[4]));
	c_sync: cover property (syncPre && (sync_q & ~cntLoad) != '0);
endmodule : tsb_timer

// [verification/tsb_pin_model.sv]
// tsb_pin_model: capture sources and quadrature encoder at the timer pins
module tsb_pin_model (
	input  wire logic                    ref_clk,
	input  wire logic [tsb_pkg::NCH-1:0] pinAOut,
	input  wire logic [tsb_pkg::NCH-1:0] pinAOe_n,
	output logic      [tsb_pkg::NCH-1:0] pinAIn,
	output logic      [3:0]              extClk
);
	import tsb_pkg::*;
	logic [NCH-1:0] srcA;
	// a driven pin reads back its own level, an undriven one sees the source
	assign pinAIn = (pinAOe_n & srcA) | (~pinAOe_n & pinAOut);
	initial begin
		srcA   = '0;
		extClk = 4'h0;
	end
	// held well past the synchroniser so both edges are seen
	task automatic pulse(input logic [NCH-1:0] m);
		srcA <= m;
		repeat (8) @(posedge ref_clk);
		srcA <= '0;
		repeat (8) @(posedge ref_clk);
	endtask : pulse
	// phases on bits 2/3; bit 2 leading counts up, four edges per step
	task automatic quad(input int n, input bit up);
		logic pa;
		logic pb;
		for (int i = 0; i < 4 * n; i++) begin
			pa = (i % 4 == 0) || (i % 4 == 1);
			pb = (i % 4 == 1) || (i % 4 == 2);
			extClk <= up ? {pb, pa, 2'h0} : {pa, pb, 2'h0};
			repeat (7) @(posedge ref_clk);
		end
	endtask : quad
endmodule : tsb_pin_model

// [verification/tb.sv]
// tb: self-checking bench for the six-channel timer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tsb_pkg::*;
	logic           ref_clk;
	logic           rst_n;
	logic           hsel;
	logic [31:0]    haddr;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [2:0]     hsize;
	logic           hresp;
	logic [31:0]    hwdata;
	logic           hready;
	logic           hreadyout;
	logic [31:0]    hrdata;
	logic [3:0]     extClk;
	logic [NCH-1:0] pinAIn;
	logic [NCH-1:0] pinAOut;
	logic [NCH-1:0] pinAOe_n;
	logic [NCH-1:0] pinBOe_n;
	logic [NCH-1:0] pinCOe_n;
	logic [NCH-1:0] pinDOe_n;
	logic [NCH-1:0] pinBOut;
	logic [NCH-1:0] pinCOut;
	logic [NCH-1:0] pinDOut;
	int             mismatches;
	int             numChecks;
	int             hi;
	int             tr;
	assign hready = hreadyout;
	tsb_timer u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .extClk(extClk), .pinAIn(pinAIn),
		.pinBIn(pinAIn), .pinCIn(pinAIn), .pinDIn(pinAIn),
		.pinAOut(pinAOut), .pinBOut(pinBOut), .pinCOut(pinCOut),
		.pinDOut(pinDOut), .pinAOe_n(pinAOe_n), .pinBOe_n(pinBOe_n),
		.pinCOe_n(pinCOe_n), .pinDOe_n(pinDOe_n)
	);
	tsb_pin_model u_pins (
		.ref_clk(ref_clk), .pinAOut(pinAOut), .pinAOe_n(pinAOe_n),
		.pinAIn(pinAIn), .extClk(extClk)
	);
	always #50 ref_clk = ~ref_clk;
	// ************************************************************
	// bus and checking helpers
	// ************************************************************
	function automatic logic [7:0] ra(input int ch, input logic [2:0] o);
		return 8'((ch + 1) * 32 + int'(o) * 4);
	endfunction : ra
	function automatic logic [15:0] ctl(input logic [2:0] p,
			input logic [2:0] c, input logic [1:0] m, input logic b);
		return 16'(p) << PSC_LSB | 16'(c) << CCLR_LSB | 16'(m) << MODE_LSB
			| 16'(b) << BUFA_BIT;
	endfunction : ctl
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic busXfer(input logic [7:0] a, input logic w,
			input logic [15:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= 3'h2;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		do @(posedge ref_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : busXfer
	task automatic busWr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		busXfer(a, 1'b1, d, q);
	endtask : busWr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		busXfer(a, 1'b0, 16'h0, q);
		chk(q, exp);
	endtask : rdChk
	// counts high cycles and level changes of one A pin
	task automatic watch(input int ch, input int n);
		logic prev;
		hi = 0;
		tr = 0;
		@(negedge ref_clk) prev = pinAOut[ch];
		repeat (n) begin
			@(negedge ref_clk);
			hi += int'(pinAOut[ch] === 1'b1);
			tr += int'(pinAOut[ch] !== prev);
			prev = pinAOut[ch];
		end
		@(posedge ref_clk);
	endtask : watch
	task automatic results;
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		chk(32'(hresp), 32'h0);
		chk(32'({pinBOut, pinCOut, pinDOut}), 32'h0);
		chk(32'({pinBOe_n, pinCOe_n, pinDOe_n}), 32'(18'h3FFFF));
		rdChk(ra(5, OFS_GRA), 32'(GR_RESET));
		busWr(8'h08, 16'h5A5A);
		rdChk(8'h08, 32'h0);
		repeat (20) @(posedge ref_clk);
		rdChk(ra(0, OFS_CNT), 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_sync;
		logic [31:0] c0;
		busWr(ADDR_SYNC, 16'h0003);
		busWr(ra(0, OFS_CTRL), ctl(3'h0, CCLR_A, 2'h0, 1'b0));
		busWr(ra(1, OFS_CTRL), ctl(3'h0, CCLR_SYNC, 2'h0, 1'b0));
		busWr(ra(0, OFS_GRA), 16'h0009);
		busWr(ra(0, OFS_CNT), 16'h1234);
		rdChk(ra(1, OFS_CNT), 32'h1234);
		rdChk(ra(2, OFS_CNT), 32'h0);
		busWr(ra(1, OFS_CNT), 16'h0000);
		busWr(ADDR_START, 16'h0003);
		repeat (53) @(posedge ref_clk);
		busWr(ADDR_START, 16'h0000);
		busXfer(ra(0, OFS_CNT), 1'b0, 16'h0, c0);
		chk(32'(c0 <= 32'h9), 32'h1);
		rdChk(ra(1, OFS_CNT), c0);
		busWr(ADDR_SYNC, 16'h0000);
		$display("test sync done");
	endtask : t_sync
	task automatic t_buf;
		busWr(ra(0, OFS_CTRL), ctl(3'h0, CCLR_A, 2'h0, 1'b1));
		busWr(ra(1, OFS_CTRL), ctl(3'h0, CCLR_A, 2'h0, 1'b1));
		for (int ch = 0; ch < 2; ch++) begin
			busWr(ra(ch, OFS_GRA), 16'h0005);
			busWr(ra(ch, OFS_GRA + 3'h2), 16'h0007);
			busWr(ra(ch, OFS_CNT), 16'h0000);
		end
		busWr(ADDR_START, 16'h0003);
		repeat (30) @(posedge ref_clk);
		busWr(ADDR_START, 16'h0000);
		rdChk(ra(0, OFS_GRA), 32'h7);
		rdChk(ra(1, OFS_GRA), 32'h5);
		busWr(ra(3, OFS_CTRL), ctl(3'h0, 3'h0, 2'h0, 1'b1));
		busWr(ra(3, OFS_IOC), 16'h0008);
		for (int k = 0; k < 2; k++) begin
			busWr(ra(3, OFS_CNT), 16'h0042 + 16'(k));
			u_pins.pulse(6'h08);
			rdChk(ra(3, OFS_GRA), 32'h42 + 32'(k));
			rdChk(ra(3, OFS_GRA + 3'h2), k ? 32'h42 : 32'hFFFF);
		end
		$display("test buffer done");
	endtask : t_buf
	task automatic t_cascade;
		busWr(ra(1, OFS_CTRL), ctl(PSC_CASCADE, 3'h0, 2'h0, 1'b0));
		busWr(ra(2, OFS_CTRL), ctl(3'h0, 3'h0, MODE_PHASE, 1'b0));
		busWr(ra(1, OFS_CNT), 16'h0000);
		busWr(ra(2, OFS_CNT), 16'h0000);
		busWr(ADDR_START, 16'h0006);
		u_pins.quad(1, 1'b0);
		rdChk(ra(2, OFS_CNT), 32'hFFFC);
		rdChk(ra(1, OFS_CNT), 32'hFFFF);
		u_pins.quad(2, 1'b1);
		rdChk(ra(2, OFS_CNT), 32'h0004);
		rdChk(ra(1, OFS_CNT), 32'h0000);
		busWr(ra(1, OFS_IOC), 16'h0008);
		busWr(ra(2, OFS_IOC), 16'h0008);
		u_pins.pulse(6'h06);
		rdChk(ra(1, OFS_GRA), 32'h0000);
		rdChk(ra(2, OFS_GRA), 32'h0004);
		busWr(ADDR_START, 16'h0000);
		$display("test cascade done");
	endtask : t_cascade
	// ch4 runs pwm 1, ch5 runs pwm 2; both start together
	task automatic t_pwm;
		busWr(ra(4, OFS_CTRL), ctl(3'h0, CCLR_A, MODE_PWM1, 1'b0));
		busWr(ra(4, OFS_IOC), 16'h0025);
		busWr(ra(4, OFS_GRA), 16'h0013);
		busWr(ra(4, OFS_GRA + 3'h1), 16'h0009);
		busWr(ra(5, OFS_CTRL), ctl(3'h0, CCLR_B, MODE_PWM2, 1'b0));
		busWr(ra(5, OFS_IOC), 16'h0002);
		busWr(ra(5, OFS_GRA), 16'h0005);
		busWr(ra(5, OFS_GRA + 3'h1), 16'h000F);
		repeat (2) @(posedge ref_clk);
		chk(32'(pinAOut[4]), 32'h1);
		busWr(ADDR_START, 16'h0030);
		repeat (40) @(posedge ref_clk);
		watch(4, 200);
		chk(32'(hi), 32'd100);
		chk(32'(tr), 32'd20);
		chk(32'(pinBOe_n[4]), 32'h1);
		watch(5, 160);
		chk(32'(hi), 32'd100);
		chk(32'(tr), 32'd20);
		chk(32'(pinBOe_n[5]), 32'h1);
		chk(32'(pinBOut[5]), 32'h0);
		busWr(ra(4, OFS_GRA + 3'h1), 16'h0013);
		busWr(ra(5, OFS_GRA), 16'h000F);
		repeat (40) @(posedge ref_clk);
		watch(4, 100);
		chk(32'(tr), 32'd0);
		watch(5, 100);
		chk(32'(tr), 32'd0);
		busWr(ADDR_START, 16'h0000);
		$display("test pwm done");
	endtask : t_pwm
	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		ref_clk    = 1'b0;
		rst_n      = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h0;
		hwdata     = 32'h0;
		mismatches = 0;
		numChecks  = 0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_sync();
		t_buf();
		t_cascade();
		t_pwm();
		results();
	end
	// the scenarios need about a thousand cycles; this leaves wide margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		results();
	end
endmodule : tb
